// *** hdl/lfm_mode_ctrl.sv ***
// Receiver mode control register with AXI4-Lite access
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "lfm_cfg.svh"
module lfm_mode_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic timer_rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`LFM_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [`LFM_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`LFM_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [`LFM_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire lfm_pkg::lfm_rx_ev_t rx_ev,
  output lfm_pkg::lfm_mode_t mode,
  output lfm_pkg::lfm_rx_ctl_t rx_ctl
);

  lfm_pkg::lfm_state_t s_q;
  lfm_pkg::lfm_state_t s_d;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic aw_now;
  logic w_now;
  logic [`LFM_ADDR_W-1:0] addr_now;
  logic [7:0] data_now;
  logic strb_now;
  logic wr_fire;
  logic wr_hit;
  logic wr_commit;
  logic wake_ev;
  logic carrier_wake;

  // Channel readies: one write and one read under way at a time
  assign awready = ~s_q.aw_got & ~s_q.bvalid;
  assign wready = ~s_q.w_got & ~s_q.bvalid;
  assign arready = ~s_q.rvalid;

  assign aw_hs = awvalid & awready;
  assign w_hs = wvalid & wready;
  assign ar_hs = arvalid & arready;

  // Address and data may arrive in either order
  assign aw_now = s_q.aw_got | aw_hs;
  assign w_now = s_q.w_got | w_hs;
  assign addr_now = s_q.aw_got ? s_q.aw_addr : awaddr;
  assign data_now = s_q.w_got ? s_q.w_data : wdata[7:0];
  assign strb_now = s_q.w_got ? s_q.w_strb0 : wstrb[0];

  assign wr_fire = aw_now & w_now & ~s_q.bvalid;
  assign wr_hit = addr_now[`LFM_ADDR_W-1:2] == `LFM_MODE_IDX;
  assign wr_commit = wr_fire & wr_hit & strb_now;

  // Pattern 2 has no pattern match: carrier seen in sniff wakes unless the wake point is NONE
  assign carrier_wake = rx_ev.carrier_detect & rx_ev.sniff_window;

  always_comb begin
    unique case (s_q.mode.core_wake_point)
      lfm_pkg::LFM_WAKE_NONE: wake_ev = 1'b0;
      lfm_pkg::LFM_WAKE_SYNC: wake_ev = rx_ev.sync_match;
      lfm_pkg::LFM_WAKE_ID: wake_ev = rx_ev.wake_id_match;
      lfm_pkg::LFM_WAKE_DATA: wake_ev = rx_ev.data_match;
    endcase
    if (s_q.mode.rx_protocol_select == lfm_pkg::LFM_PROTO_P2 &&
        s_q.mode.core_wake_point != lfm_pkg::LFM_WAKE_NONE) begin
      wake_ev = carrier_wake;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.ctl.trim_load = 1'b0;
    s_d.ctl.slicer_load = 1'b0;
    s_d.ctl.detector_clear = 1'b0;
    s_d.ctl.core_wake = wake_ev;
    if (aw_hs) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (w_hs) begin
      s_d.w_got = 1'b1;
      s_d.w_data = wdata[7:0];
      s_d.w_strb0 = wstrb[0];
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_hit ? `LFM_RESP_OKAY : `LFM_RESP_SLVERR;
    end
    if (wr_commit) begin
      s_d.mode.update_gate = data_now[`LFM_GATE_BIT];
      if (data_now[`LFM_GATE_BIT]) begin
        s_d.mode = lfm_pkg::lfm_mode_t'(data_now);
        s_d.ctl.trim_load = data_now[`LFM_SEL_BIT];
        s_d.ctl.slicer_load = ~data_now[`LFM_SEL_BIT];
        s_d.ctl.detector_clear = data_now[`LFM_PURGE_BIT];
      end
    end
    if (s_q.bvalid & bready) begin
      s_d.bvalid = 1'b0;
    end
    if (ar_hs) begin
      s_d.rvalid = 1'b1;
      if (araddr[`LFM_ADDR_W-1:2] == `LFM_MODE_IDX) begin
        s_d.rresp = `LFM_RESP_OKAY;
      end else begin
        s_d.rresp = `LFM_RESP_SLVERR;
      end
    end
    if (s_q.rvalid & rready) begin
      s_d.rvalid = 1'b0;
    end
    if (timer_rst) begin
      s_d.mode.update_gate = `LFM_GATE_RST;
    end
    // Purge holds the amplifier off over both power modes
    s_d.ctl.amp_enable = ~s_d.mode.detector_purge_amp_off &
      (s_d.mode.amp_power_mode | rx_ev.sniff_window);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rresp = s_q.rresp;
  // Fields cannot be read back; software keeps a copy
  assign rdata = `LFM_RDATA_NONE;
  assign mode = s_q.mode;
  assign rx_ctl = s_q.ctl;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic ungated;
  logic gated;
  assign ungated = wr_commit & ~data_now[`LFM_GATE_BIT];
  assign gated = wr_commit & data_now[`LFM_GATE_BIT];

  a_gate_hold_fields: assert property (
    ungated |=> s_q.mode[6:0] == $past(s_q.mode[6:0]))
    else $error("Ungated write changed mode fields");

  a_ungated_no_load: assert property (
    ungated |=> !rx_ctl.trim_load && !rx_ctl.slicer_load)
    else $error("Load strobe without gate");

  a_trim_load_pulse: assert property (
    gated && data_now[`LFM_SEL_BIT] |=> rx_ctl.trim_load ##1 !rx_ctl.trim_load)
    else $error("Trim load pulse missing or long");

  a_trim_not_slicer: assert property (
    rx_ctl.trim_load |-> !rx_ctl.slicer_load && mode.trim_load_strobe)
    else $error("Trim load touched slicer");

  a_slicer_load_only: assert property (
    gated && !data_now[`LFM_SEL_BIT] |=> rx_ctl.slicer_load && !rx_ctl.trim_load)
    else $error("Slicer load wrong");

  a_purge_amp_off: assert property (
    mode.detector_purge_amp_off |-> !rx_ctl.amp_enable)
    else $error("Amplifier on while purged");

  a_purge_clear: assert property (
    gated && data_now[`LFM_PURGE_BIT] |=> rx_ctl.detector_clear)
    else $error("Detector clear missing");

  a_amp_continuous: assert property (
    !mode.detector_purge_amp_off && mode.amp_power_mode &&
    !timer_rst && !wr_commit |=> rx_ctl.amp_enable)
    else $error("Amplifier not continuously on");

  a_amp_sniff_only: assert property (
    !mode.amp_power_mode && !wr_commit && !rx_ev.sniff_window
    |=> !rx_ctl.amp_enable)
    else $error("Amplifier on outside sniff");

  a_wake_none: assert property (
    mode.core_wake_point == lfm_pkg::LFM_WAKE_NONE |=> !rx_ctl.core_wake)
    else $error("Core woken with wake point off");

  a_wake_sync: assert property (
    mode.rx_protocol_select != lfm_pkg::LFM_PROTO_P2 &&
    mode.core_wake_point == lfm_pkg::LFM_WAKE_SYNC &&
    rx_ev.sync_match |=> rx_ctl.core_wake)
    else $error("No wake on sync match");

  a_wake_ident: assert property (
    mode.rx_protocol_select != lfm_pkg::LFM_PROTO_P2 &&
    mode.core_wake_point == lfm_pkg::LFM_WAKE_ID |=>
    rx_ctl.core_wake == $past(rx_ev.wake_id_match))
    else $error("Wake identifier wake wrong");

  a_wake_data: assert property (
    mode.rx_protocol_select != lfm_pkg::LFM_PROTO_P2 &&
    mode.core_wake_point == lfm_pkg::LFM_WAKE_DATA |=>
    rx_ctl.core_wake == $past(rx_ev.data_match))
    else $error("Data pattern wake wrong");

  a_proto_write: assert property (
    gated && !timer_rst |=> mode.rx_protocol_select == $past(data_now[1:0]))
    else $error("Protocol field not written");

  a_timer_reset_gate: assert property (
    timer_rst |=> !mode.update_gate && (mode[6:0] == $past(mode[6:0]) || $past(gated)))
    else $error("Timer reset handling wrong");

  a_carrier_wake: assert property (
    mode.rx_protocol_select == lfm_pkg::LFM_PROTO_P2 &&
    mode.core_wake_point != lfm_pkg::LFM_WAKE_NONE |=>
    rx_ctl.core_wake == $past(carrier_wake))
    else $error("Carrier wake wrong");

  a_read_zero: assert property (
    rvalid |-> rdata == `LFM_RDATA_NONE)
    else $error("Read returned data");

  a_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped");

  a_rresp_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rresp))
    else $error("Read response dropped");

  a_write_answer: assert property (
    aw_hs && w_hs |=> bvalid)
    else $error("Write response late");

  a_read_answer: assert property (
    ar_hs |=> rvalid && rdata == `LFM_RDATA_NONE)
    else $error("Read response late");

  a_write_refused: assert property (
    bvalid |-> !awready && !wready)
    else $error("Write taken while response pending");

  a_read_refused: assert property (
    rvalid |-> !arready)
    else $error("Read taken while response pending");

  a_bad_addr: assert property (
    wr_fire && !wr_hit && !timer_rst |=> bresp == `LFM_RESP_SLVERR && $stable(mode))
    else $error("Stray write changed register");

  a_strobe_off: assert property (
    wr_fire && wr_hit && !strb_now && !timer_rst |=> $stable(mode))
    else $error("Masked write changed register");

  a_gate_cleared: assert property (
    ungated |=> !mode.update_gate)
    else $error("Gate not cleared by write");

  a_slicer_pulse: assert property (
    rx_ctl.slicer_load |=> !rx_ctl.slicer_load)
    else $error("Slicer load pulse long");

  a_clear_pulse: assert property (
    rx_ctl.detector_clear |=> !rx_ctl.detector_clear)
    else $error("Detector clear pulse long");

  c_trim_load: cover property (rx_ctl.trim_load);
  c_slicer_load: cover property (rx_ctl.slicer_load);
  c_ungated: cover property (ungated);
  c_core_wake: cover property (rx_ctl.core_wake);
  c_carrier_wake: cover property (rx_ctl.core_wake && mode.rx_protocol_select == lfm_pkg::LFM_PROTO_P2);

endmodule : lfm_mode_ctrl

// *** common/lfm_cfg.svh ***
// Constants for the receiver mode control register block
`ifndef LFM_CFG_SVH
`define LFM_CFG_SVH
`define LFM_ADDR_W 8
`define LFM_DATA_W 32
`define LFM_MODE_IDX 6'h00
`define LFM_GATE_BIT 7
`define LFM_SEL_BIT 6
`define LFM_PURGE_BIT 5
`define LFM_AMP_BIT 4
`define LFM_WAKE_HI 3
`define LFM_WAKE_LO 2
`define LFM_PROTO_HI 1
`define LFM_PROTO_LO 0
`define LFM_GATE_RST 1'b0
`define LFM_RESP_OKAY 2'b00
`define LFM_RESP_SLVERR 2'b10
`define LFM_RDATA_NONE 32'h0000_0000
`endif

// *** common/lfm_pkg.sv ***
// Types for the receiver mode control register block
`include "lfm_cfg.svh"
package lfm_pkg;
  typedef enum logic [1:0] {
    LFM_PROTO_P2 = 2'h0,
    LFM_PROTO_P1A = 2'h1,
    LFM_PROTO_P1C = 2'h3,
    LFM_PROTO_P1B = 2'h2
  } lfm_proto_t;
  typedef enum logic [1:0] {
    LFM_WAKE_NONE = 2'h0,
    LFM_WAKE_SYNC = 2'h1,
    LFM_WAKE_DATA = 2'h3,
    LFM_WAKE_ID = 2'h2
  } lfm_wake_t;
  // Field order matches the written byte, bit 7 first
  typedef struct packed {
    logic update_gate;
    logic trim_load_strobe;
    logic detector_purge_amp_off;
    logic amp_power_mode;
    lfm_wake_t core_wake_point;
    lfm_proto_t rx_protocol_select;
  } lfm_mode_t;
  typedef struct packed {
    logic sniff_window;
    logic carrier_detect;
    logic sync_match;
    logic wake_id_match;
    logic data_match;
  } lfm_rx_ev_t;
  typedef struct packed {
    logic trim_load;
    logic slicer_load;
    logic detector_clear;
    logic amp_enable;
    logic core_wake;
  } lfm_rx_ctl_t;
  typedef struct packed {
    logic aw_got;
    logic [`LFM_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    lfm_mode_t mode;
    lfm_rx_ctl_t ctl;
  } lfm_state_t;
endpackage : lfm_pkg

// *** tb/lfm_mode_ctrl_tb.sv ***
// Self-checking bench for the receiver mode control register block
`timescale 1ns/1ps
`include "lfm_cfg.svh"
module lfm_mode_ctrl_tb;
  logic aclk, aresetn, timer_rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [`LFM_ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  lfm_pkg::lfm_rx_ev_t rx_ev;
  lfm_pkg::lfm_mode_t mode, m;
  lfm_pkg::lfm_rx_ctl_t rx_ctl, c;
  int bad_count, n_tests, cyc;
  // Written byte, expected mode byte, expected rx_ctl in the bvalid cycle
  typedef struct packed {logic [7:0] wd; logic [7:0] md; logic [4:0] ctl;} lfm_row_t;
  localparam lfm_row_t ROWS [8] = '{'{8'hc1, 8'hc1, 5'h10}, '{8'h86, 8'h86, 5'h08},
    '{8'ha7, 8'ha7, 5'h0c}, '{8'h5a, 8'h27, 5'h00}, '{8'hdb, 8'hdb, 5'h12},
    '{8'h0f, 8'h5b, 5'h02}, '{8'h9c, 8'h9c, 5'h0a}, '{8'hf5, 8'hf5, 5'h14}};
  lfm_mode_ctrl u_lfm_mode_ctrl (.aclk(aclk), .aresetn(aresetn), .timer_rst(timer_rst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .rx_ev(rx_ev), .mode(mode), .rx_ctl(rx_ctl));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_mode(input logic [7:0] g, input logic [7:0] e);
    chk({24'h0, g}, {24'h0, e});
  endtask : chk_mode
  task automatic chk_ctl(input logic [4:0] g, input logic [4:0] e);
    chk({27'h0, g}, {27'h0, e});
  endtask : chk_ctl
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk({30'h0, g}, {30'h0, e});
  endtask : chk_resp
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    chk(g, e);
  endtask : chk_data
  // Write: AW and W offered together, each dropped once taken, bready held to B
  task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
    logic aw, w, done;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= wd; wstrb <= s; bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      if (bvalid === 1'b1) begin
        r = bresp; m = mode; c = rx_ctl; done = 1'b1;
      end
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ar, done;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      ar = arvalid & arready;
      if (rvalid === 1'b1) begin
        r = rresp; d = rdata; done = 1'b1;
      end
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask : rd
  task automatic ev_chk(input logic [4:0] ev, input logic [4:0] e);
    @(posedge aclk);
    rx_ev <= ev;
    @(posedge aclk);
    @(negedge aclk);
    chk_ctl(rx_ctl, e);
  endtask : ev_chk
  initial begin
    aresetn = 1'b0; timer_rst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; awprot = 3'h0; arprot = 3'h0;
    wdata = 32'h0; wstrb = 4'h0; rx_ev = '0; bad_count = 0; n_tests = 0; cyc = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_mode(mode, 8'h00);
    chk_ctl(rx_ctl, 5'h00);
    $display("Test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {24'hffffff, ROWS[i].wd}, 4'hf);
      chk_resp(r, `LFM_RESP_OKAY);
      chk_mode(m, ROWS[i].md);
      chk_ctl(c, ROWS[i].ctl);
    end
    $display("Test table done");
    wr(8'h04, 32'h0000_00c0, 4'h1);
    chk_resp(r, `LFM_RESP_SLVERR);
    chk_mode(m, 8'hf5);
    wr(8'h00, 32'h0000_00c0, 4'he);
    chk_resp(r, `LFM_RESP_OKAY);
    chk_ctl(c, 5'h00);
    chk_mode(m, 8'hf5);
    rd(8'h00);
    chk_resp(r, `LFM_RESP_OKAY);
    chk_data(d, 32'h0);
    rd(8'h08);
    chk_resp(r, `LFM_RESP_SLVERR);
    @(posedge aclk);
    timer_rst <= 1'b1;
    @(posedge aclk);
    timer_rst <= 1'b0;
    @(negedge aclk);
    chk_mode(mode, 8'h75);
    $display("Test bus and timer reset done");
    for (int w = 0; w < 4; w++) begin
      wr(8'h00, 32'h81 | (32'(w) << 2), 4'h1);
      for (int e = 0; e < 3; e++) begin
        ev_chk(5'b00100 >> e, {4'h0, w != 0 && e == w - 1});
      end
    end
    wr(8'h00, 32'h0000_0084, 4'h1);
    ev_chk(5'h08, 5'h00);
    ev_chk(5'h18, 5'h03);
    $display("Test receiver done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_mode(mode, 8'h00);
    $display("Test second reset done");
    finish_test();
  end
endmodule : lfm_mode_ctrl_tb
